// *** logic/acle_defs.vh ***
// Register map, field positions, reset values and timing for the converter control block
`ifndef ACLE_DEFS_VH
`define ACLE_DEFS_VH
`define ACLE_AW 8
`define ACLE_OFF_CTRL 8'h00
`define ACLE_OFF_STAT 8'h04
`define ACLE_OFF_DATA 8'h08
`define ACLE_OFF_INTR 8'h0C
`define ACLE_OFF_LIM0 8'h10
`define ACLE_OFF_LIM3 8'h1C
`define ACLE_OFF_ANA 8'h20
`define ACLE_OFF_CMP 8'h24
`define ACLE_CTRL_MASK 32'h0017_FB1B
`define ACLE_BIT_START 0
`define ACLE_BIT_PWR 1
`define ACLE_BIT_REFBUF 3
`define ACLE_BIT_REFSEL 4
`define ACLE_BIT_REFSCALE 8
`define ACLE_BIT_SCALE 9
`define ACLE_BIT_CLKEN 11
`define ACLE_CH_LSB 12
`define ACLE_DIV_LSB 17
`define ACLE_BIT_ALIGN 20
`define ACLE_FLAG_LSB 16
`define ACLE_BIT_PEND 22
`define ACLE_LIM_HIEN 30
`define ACLE_LIM_LOEN 29
`define ACLE_LIM_CH_LSB 24
`define ACLE_LIM_HI_LSB 12
`define ACLE_LIM_RESET 32'h003F_F000
`define ACLE_LIM_MASK 32'h7F3F_F3FF
`define ACLE_CONV_CYCLES 11'h400
`define ACLE_PWRUP_NS 1000
`define ACLE_CLK_NS 25
`define ACLE_PWRUP_CYCLES 16'h0028
`endif

// *** logic/acle_core.v ***
// Converter control, status, result justification and four-entry limit engine
//
// Function
// - Default: result low bits, upper zero
// - Align bit set: result high, low six zero
// - Four limit entries: high, low, channel
// - Compare only entries matching converted channel
// - Enabled high check: above sets flag
// - Enabled low check: below sets flag
// - Separate high and low enables each
// - Channel field and result kept at interrupt
// - Channel field picks next conversion input
// - Divider field scales external inputs
// - Bits 9, 8 halve input, reference
// - Bit 4 picks reference source
// - Clock, refbuf, power enables, reset off
// - Status active and power-up delay bits
// - Status overflow of last conversion
// - Write-one-clear interrupt flags
// - Completion flag set per conversion
// - Interrupt when flag and enable set
// - Pending bit summarises enabled flags
// - Comparator enables, flags, interrupt gating
// - Conversion lasts 1024 converter clocks
// - Start bit launches conversion
`timescale 1ns/100ps
`include "acle_defs.vh"
module acle_core (
   input wire i_clk, // Peripheral clock
   input wire i_rst_n, // Synchronous reset, active low
   input wire [7:0] i_addr, // Byte address
   input wire [31:0] i_wdata, // Write data
   input wire i_wr, // Write strobe
   input wire i_rd, // Read strobe
   output reg [31:0] o_rdata, // Read data, cycle after strobe
   input wire i_adc_tick, // Converter clock tick from the gated divider
   input wire [9:0] i_mod_result, // Modulator word at end of conversion
   input wire i_mod_overflow, // Modulator overflow at end of conversion
   input wire i_ref_ready, // Reference settled, asynchronous level
   input wire [3:0] i_cmp_cross, // Comparator crossings, asynchronous levels
   output reg [4:0] o_input_channel, // Mux select
   output reg [1:0] o_ext_divider, // External input divider
   output reg o_input_halve, // Halve converter input
   output reg o_ref_halve, // Halve bandgap
   output reg o_ref_select, // 0 bandgap, 1 half supply
   output reg o_conv_clk_en, // Converter clock gate
   output reg o_refbuf_power, // Reference buffer power
   output reg o_conv_power, // Converter power
   output reg o_conv_run, // Modulator running
   output reg [3:0] o_cmp_enable, // Comparator enables
   output reg o_converter_interrupt_line, // Converter interrupt
   output reg o_cmp_wake_interrupt // Comparator wake interrupt
);
   // Control register holds
   reg [31:0] ctrl;
   // Limit entries, one word each
   reg [31:0] limit [0:3];
   // Flags: bit0 done, 1 ref ready, 2 above, 3 below, 4 overflow
   reg [4:0] flags;
   // Interrupt enables, same bit order as flags
   reg [4:0] irq_on;
   // Justified result as software reads it
   reg [15:0] result;
   // Overflow of the last finished conversion
   reg overflow_stat;
   // Conversion in progress and its converter tick count
   reg active;
   reg [10:0] conv_cnt;
   // Power-up delay count and the power bit one cycle late
   reg [15:0] pwrup_cnt;
   reg pwr_q;
   // Comparator enable, status, wake enables, global enable
   reg [3:0] cmp_en;
   reg [3:0] cmp_flag;
   reg [3:0] cmp_wake_en;
   reg cmp_global;
   // Two-stage synchronisers for asynchronous levels
   reg ref_s1;
   reg ref_s2;
   reg ref_s3;
   reg [3:0] cmp_s1;
   reg [3:0] cmp_s2;
   reg [3:0] cmp_s3;
   // Next-state values for flags and read data
   reg [4:0] next_flags;
   reg [31:0] next_rdata;
   // Decoded strobes and events
   wire [3:0] lim_wr;
   wire conv_done;
   wire ref_rise;
   // Crossings after the enable mask
   wire [3:0] cmp_rise;
   wire above_hit;
   wire below_hit;
   // Justified copy of the modulator word
   wire [15:0] aligned;
   // Summary of enabled flags
   wire pending;
   // Front end still settling, including the cycle before the load
   wire pwrup_busy;
   // Loop index for the comparator bits
   integer k;
   // Loop index for the limit entries
   integer j;

   // Word select for a limit entry
   // Misaligned or out-of-range addresses select nothing
   function [3:0] lim_sel;
      input [7:0] a;
      begin
         lim_sel = 4'h0;
         if (a >= `ACLE_OFF_LIM0 && a <= `ACLE_OFF_LIM3 && a[1:0] == 2'b00) begin
            lim_sel[a[3:2]] = 1'b1;
         end
      end
   endfunction

   // Compare one entry against a new result
   // Strict compares: a result equal to a threshold never trips
   function [1:0] lim_eval;
      input [31:0] e;
      input [4:0] ch;
      input [9:0] r;
      reg match;
      begin
         match = (e[`ACLE_LIM_CH_LSB +: 5] == ch);
         lim_eval[1] = match && e[`ACLE_LIM_HIEN] && (r > e[`ACLE_LIM_HI_LSB +: 10]);
         lim_eval[0] = match && e[`ACLE_LIM_LOEN] && (r < e[9:0]);
      end
   endfunction

   assign lim_wr = i_wr ? lim_sel(i_addr) : 4'h0;
   // Conversion ends on the last converter tick of the count
   assign conv_done = active && i_adc_tick && (conv_cnt == `ACLE_CONV_CYCLES - 11'h001);
   // Rising edges taken from the second and third stages only
   assign ref_rise = ref_s2 && !ref_s3;
   assign cmp_rise = cmp_s2 & ~cmp_s3 & cmp_en;
   assign pwrup_busy = (pwrup_cnt != 16'h0000) || (ctrl[`ACLE_BIT_PWR] && !pwr_q);

   // Any matching entry raises the shared flag
   // All entries are judged in parallel; the flags are shared, so
   // software cannot tell from them alone which entry tripped
   wire [1:0] ev0 = lim_eval(limit[0], ctrl[`ACLE_CH_LSB +: 5], i_mod_result);
   wire [1:0] ev1 = lim_eval(limit[1], ctrl[`ACLE_CH_LSB +: 5], i_mod_result);
   wire [1:0] ev2 = lim_eval(limit[2], ctrl[`ACLE_CH_LSB +: 5], i_mod_result);
   wire [1:0] ev3 = lim_eval(limit[3], ctrl[`ACLE_CH_LSB +: 5], i_mod_result);
   assign above_hit = ev0[1] | ev1[1] | ev2[1] | ev3[1];
   assign below_hit = ev0[0] | ev1[0] | ev2[0] | ev3[0];

   // Justify the raw word
   assign aligned = ctrl[`ACLE_BIT_ALIGN] ? {i_mod_result, 6'h00}
                                          : {6'h00, i_mod_result};
   assign pending = |(flags & irq_on);

   // Synchronise reference ready and comparator levels
   // The third stage only serves edge detection; only stage two reads stage one
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
         ref_s3 <= 1'b0;
         cmp_s1 <= 4'h0;
         cmp_s2 <= 4'h0;
         cmp_s3 <= 4'h0;
      end else begin
         ref_s1 <= i_ref_ready;
         ref_s2 <= ref_s1;
         ref_s3 <= ref_s2;
         cmp_s1 <= i_cmp_cross;
         cmp_s2 <= cmp_s1;
         cmp_s3 <= cmp_s2;
      end
   end

   // Control register; start clears itself at completion
   // Reserved bits are masked so they always read zero
   // A write in the completing cycle wins, keeping a fresh start
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         ctrl <= 32'h0000_0000;
      end else if (i_wr && i_addr == `ACLE_OFF_CTRL) begin
         ctrl <= i_wdata & `ACLE_CTRL_MASK;
      end else if (conv_done) begin
         ctrl[`ACLE_BIT_START] <= 1'b0;
      end
   end

   // Limit entries; writes while active are software's hazard
   // Nothing blocks a write during a conversion: software polls the
   // active status first or a result may meet a half-written entry
   always @(posedge i_clk) begin
      for (j = 0; j < 4; j = j + 1) begin
         if (!i_rst_n) begin
            limit[j] <= `ACLE_LIM_RESET;
         end else if (lim_wr[j]) begin
            limit[j] <= i_wdata & `ACLE_LIM_MASK;
         end
      end
   end

   // Conversion sequencer: start launches when powered and clocked
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         active <= 1'b0;
         conv_cnt <= 11'h000;
      end else if (!active) begin
         conv_cnt <= 11'h000;
         // Launch only once the front end has finished powering up;
         // the busy term also covers the cycle before the count loads,
         // so a start written together with power still waits
         if (ctrl[`ACLE_BIT_START] && ctrl[`ACLE_BIT_CLKEN] && ctrl[`ACLE_BIT_PWR]
             && !pwrup_busy) begin
            active <= 1'b1;
         end
      end else if (conv_done) begin
         active <= 1'b0;
      end else if (i_adc_tick) begin
         conv_cnt <= conv_cnt + 11'h001;
      end
   end

   // Power-up delay after converter power turns on
   // The count reloads on every rising edge of the power bit, so a
   // quick off-on cycle restarts the whole delay
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         pwr_q <= 1'b0;
         pwrup_cnt <= 16'h0000;
      end else begin
         pwr_q <= ctrl[`ACLE_BIT_PWR];
         if (ctrl[`ACLE_BIT_PWR] && !pwr_q) begin
            pwrup_cnt <= `ACLE_PWRUP_CYCLES;
         end else if (!ctrl[`ACLE_BIT_PWR]) begin
            pwrup_cnt <= 16'h0000;
         end else if (pwrup_cnt != 16'h0000) begin
            pwrup_cnt <= pwrup_cnt - 16'h0001;
         end
      end
   end

   // Result and overflow captured with completion; held until next one
   // Holding the word lets an interrupt handler read the offending value
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         result <= 16'h0000;
         overflow_stat <= 1'b0;
      end else if (conv_done) begin
         result <= aligned;
         overflow_stat <= i_mod_overflow;
      end
   end

   // Sticky flags: a set in the clearing cycle wins
   // Clear first, then set, so an event in the clearing cycle survives
   always @* begin
      next_flags = flags;
      if (i_wr && i_addr == `ACLE_OFF_INTR) begin
         next_flags = flags & ~i_wdata[`ACLE_FLAG_LSB +: 5];
      end
      if (conv_done) begin
         next_flags[0] = 1'b1;
         if (above_hit) begin
            next_flags[2] = 1'b1;
         end
         if (below_hit) begin
            next_flags[3] = 1'b1;
         end
         if (i_mod_overflow) begin
            next_flags[4] = 1'b1;
         end
      end
      if (ref_rise) begin
         next_flags[1] = 1'b1;
      end
   end

   // Flags and enables
   // Enables are plain read-write bits beside the flags
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         flags <= 5'h00;
         irq_on <= 5'h00;
      end else begin
         flags <= next_flags;
         if (i_wr && i_addr == `ACLE_OFF_INTR) begin
            irq_on <= i_wdata[4:0];
         end
      end
   end

   // Comparator block: own enables, sticky status, gated wake
   // Only rising edges of enabled comparators set status
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         cmp_en <= 4'h0;
         cmp_flag <= 4'h0;
         cmp_wake_en <= 4'h0;
         cmp_global <= 1'b0;
      end else begin
         if (i_wr && i_addr == `ACLE_OFF_ANA) begin
            cmp_en <= i_wdata[3:0];
            cmp_wake_en <= i_wdata[7:4];
            cmp_global <= i_wdata[8];
         end
         for (k = 0; k < 4; k = k + 1) begin
            if (cmp_rise[k]) begin
               cmp_flag[k] <= 1'b1;
            end else if (i_wr && i_addr == `ACLE_OFF_CMP && i_wdata[k]) begin
               cmp_flag[k] <= 1'b0;
            end
         end
      end
   end

   // Outputs registered straight from control state
   // One cycle of latency on every analog control line
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_input_channel <= 5'h00;
         o_ext_divider <= 2'h0;
         o_input_halve <= 1'b0;
         o_ref_halve <= 1'b0;
         o_ref_select <= 1'b0;
         o_conv_clk_en <= 1'b0;
         o_refbuf_power <= 1'b0;
         o_conv_power <= 1'b0;
         o_conv_run <= 1'b0;
         o_cmp_enable <= 4'h0;
         o_converter_interrupt_line <= 1'b0;
         o_cmp_wake_interrupt <= 1'b0;
      end else begin
         o_input_channel <= ctrl[`ACLE_CH_LSB +: 5];
         o_ext_divider <= ctrl[`ACLE_DIV_LSB +: 2];
         o_input_halve <= ctrl[`ACLE_BIT_SCALE];
         o_ref_halve <= ctrl[`ACLE_BIT_REFSCALE];
         o_ref_select <= ctrl[`ACLE_BIT_REFSEL];
         o_conv_clk_en <= ctrl[`ACLE_BIT_CLKEN];
         o_refbuf_power <= ctrl[`ACLE_BIT_REFBUF];
         o_conv_power <= ctrl[`ACLE_BIT_PWR];
         o_conv_run <= active;
         o_cmp_enable <= cmp_en;
         o_converter_interrupt_line <= pending;
         o_cmp_wake_interrupt <= cmp_global && |(cmp_flag & cmp_wake_en);
      end
   end

   // Read mux; unmapped reads return zero
   // Decoded from the live address; the data flop below adds the cycle
   always @* begin
      next_rdata = 32'h0000_0000;
      case (i_addr)
         `ACLE_OFF_CTRL: next_rdata = ctrl;
         `ACLE_OFF_STAT: next_rdata = {28'h000_0000, overflow_stat,
                                       pwrup_busy, 1'b0, active};
         `ACLE_OFF_DATA: next_rdata = {16'h0000, result};
         `ACLE_OFF_INTR: next_rdata = {9'h000, pending, 1'b0, flags,
                                       11'h000, irq_on};
         `ACLE_OFF_ANA: next_rdata = {23'h00_0000, cmp_global, cmp_wake_en, cmp_en};
         `ACLE_OFF_CMP: next_rdata = {28'h000_0000, cmp_flag};
         default: begin
            if (lim_sel(i_addr) != 4'h0) begin
               next_rdata = limit[i_addr[3:2]];
            end
         end
      endcase
   end

   // Read data stands only in the cycle after the strobe
   // Zero outside reads keeps the bus quiet for or-combined readers
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end
endmodule // acle_core

// *** tb/acle_afe_model.sv ***
// Behavioural model of the analog front end: modulator, reference and converter clock
`timescale 1ns/100ps
module acle_afe_model (
   input wire i_clk, // Peripheral clock
   input wire i_clk_en, // Converter clock gate from the block
   input wire i_refbuf, // Reference buffer power from the block
   input wire i_run, // Modulator running
   input wire [9:0] i_value, // Word the bench wants converted
   input wire i_ovf, // Overflow the bench wants reported
   output logic o_tick, // Converter clock tick
   output logic [9:0] o_result, // Modulator word
   output logic o_ovf, // Modulator overflow
   output logic o_ready // Reference settled
);
   logic [3:0] settle; // Reference settling count
   initial begin
      o_tick = 1'h0;
      settle = 4'h0;
   end
   // Half-rate ticks only while gated on, so a conversion is the slow case
   always @(posedge i_clk) begin
      o_tick <= i_clk_en & ~o_tick;
      settle <= !i_refbuf ? 4'h0 : (settle == 4'hF) ? settle : settle + 4'h1;
   end
   assign o_ready = (settle == 4'hF);
   // Outside a run the lines carry no valid word, so show the inverse
   assign o_result = i_run ? i_value : ~i_value;
   assign o_ovf = i_run ? i_ovf : ~i_ovf;
endmodule // acle_afe_model

// *** tb/acle_core_chk.sv ***
// Port-level assertions for the converter control block
`timescale 1ns/100ps
module acle_core_chk (
   input wire i_clk,
   input wire i_rst_n,
   input wire [7:0] i_addr,
   input wire [31:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [31:0] o_rdata,
   input wire [4:0] o_input_channel,
   input wire [1:0] o_ext_divider,
   input wire o_input_halve,
   input wire o_ref_halve,
   input wire o_ref_select,
   input wire o_conv_clk_en,
   input wire o_refbuf_power,
   input wire o_conv_power,
   input wire o_conv_run,
   input wire [3:0] o_cmp_enable,
   input wire o_converter_interrupt_line,
   input wire o_cmp_wake_interrupt
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire ctrl_wr = i_wr && (i_addr == 8'h00); // Control register write
   logic [11:0] run_cnt; // Cycles the modulator has run
   // Count run length; model ticks every second cycle
   always @(posedge i_clk) begin
      run_cnt <= (!i_rst_n || !o_conv_run) ? 12'h000 : run_cnt + 12'h001;
   end
   rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
      else $error("read data not zero without a read");
   reset_off_a: assert property (!$past(i_rst_n) |-> !o_conv_power && !o_conv_clk_en
      && !o_refbuf_power && !o_conv_run && !o_converter_interrupt_line)
      else $error("outputs active after reset");
   gate_copy_a: assert property (ctrl_wr |-> ##2
      o_conv_clk_en == $past(i_wdata[11], 2) && o_refbuf_power == $past(i_wdata[3], 2)
      && o_conv_power == $past(i_wdata[1], 2))
      else $error("gate outputs do not follow control write");
   chan_copy_a: assert property (ctrl_wr |-> ##2
      o_input_channel == $past(i_wdata[16:12], 2)
      && o_ext_divider == $past(i_wdata[18:17], 2))
      else $error("channel or divider does not follow control write");
   chan_hold_a: assert property (!$past(ctrl_wr) |=> $stable(o_input_channel)
      && $stable(o_ext_divider))
      else $error("channel changed without a write");
   scale_copy_a: assert property (ctrl_wr |-> ##2
      o_input_halve == $past(i_wdata[9], 2) && o_ref_halve == $past(i_wdata[8], 2)
      && o_ref_select == $past(i_wdata[4], 2))
      else $error("scale or reference select wrong");
   cmp_copy_a: assert property (i_wr && i_addr == 8'h20 |-> ##2
      o_cmp_enable == $past(i_wdata[3:0], 2))
      else $error("comparator enables wrong");
   run_start_a: assert property ($rose(o_conv_run) |-> o_conv_power && o_conv_clk_en)
      else $error("conversion started unpowered");
   run_length_a: assert property ($fell(o_conv_run) |->
      run_cnt >= 12'h7FE && run_cnt <= 12'h801)
      else $error("conversion length wrong");
   cover property ($fell(o_conv_run));
   cover property ($rose(o_converter_interrupt_line));
   cover property ($rose(o_cmp_wake_interrupt));
endmodule // acle_core_chk
bind acle_core acle_core_chk chk_u (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
   .o_rdata, .o_input_channel, .o_ext_divider, .o_input_halve, .o_ref_halve, .o_ref_select,
   .o_conv_clk_en, .o_refbuf_power, .o_conv_power, .o_conv_run, .o_cmp_enable,
   .o_converter_interrupt_line, .o_cmp_wake_interrupt);

// *** tb/acle_core_tb.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`include "acle_defs.vh"
module acle_core_tb;
   logic i_clk, i_rst_n, i_wr, i_rd, ovf_set;
   logic [7:0] i_addr;
   logic [31:0] i_wdata;
   logic [3:0] i_cmp_cross;
   logic [9:0] value; // Word the model converts
   wire [31:0] o_rdata;
   wire [9:0] i_mod_result;
   wire [4:0] o_input_channel;
   wire [3:0] o_cmp_enable;
   wire [1:0] o_ext_divider;
   wire i_adc_tick, i_mod_overflow, i_ref_ready, o_input_halve, o_ref_halve, o_ref_select;
   wire o_conv_clk_en, o_refbuf_power, o_conv_power, o_conv_run;
   wire o_converter_interrupt_line, o_cmp_wake_interrupt;
   int n_fail = 0;
   int cmp_count = 0;
   int cycles = 0;
   localparam logic [31:0] BASE = 32'h0004_5B1A; // Powered, clocked, channel 5, divider 2, halving and reference select on, align off
   logic [31:0] lim [4] = '{32'h4520_0000, 32'h253F_F100, 32'h6600_03FF, 32'h0500_03FF};
   acle_core dut_u (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_adc_tick,
      .i_mod_result, .i_mod_overflow, .i_ref_ready, .i_cmp_cross, .o_input_channel,
      .o_ext_divider, .o_input_halve, .o_ref_halve, .o_ref_select, .o_conv_clk_en,
      .o_refbuf_power, .o_conv_power, .o_conv_run, .o_cmp_enable, .o_converter_interrupt_line,
      .o_cmp_wake_interrupt);
   acle_afe_model afe_u (.i_clk, .i_clk_en(o_conv_clk_en), .i_refbuf(o_refbuf_power),
      .i_run(o_conv_run), .i_value(value), .i_ovf(ovf_set), .o_tick(i_adc_tick),
      .o_result(i_mod_result), .o_ovf(i_mod_overflow), .o_ready(i_ref_ready));
   task automatic stop_test();
      if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'h1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_rd <= 1'h1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'h0;
      #1 chk(o_rdata, e);
   endtask
   // One conversion, then result, status, flags and control checked
   task automatic conv(input logic [9:0] v, input logic o, input logic [31:0] c,
      input logic [31:0] d, input logic [31:0] fl);
      int k;
      k = 0;
      value <= v;
      ovf_set <= o;
      wr(8'h00, c | 32'h0000_0001);
      while (!o_conv_run && k < 20) begin
         @(posedge i_clk);
         k++;
      end
      while (o_conv_run && k < 3000) begin
         @(posedge i_clk);
         k++;
      end
      repeat (3) @(posedge i_clk);
      rd(8'h08, d);
      rd(8'h04, {28'h000_0000, o, 3'h0});
      rd(8'h0C, fl);
      rd(8'h00, c);
      chk(o_converter_interrupt_line, 32'h0000_0001);
   endtask
   initial begin
      i_clk = 1'h0;
      forever #12.5 i_clk = ~i_clk;
   end
   // Watchdog against a hung handshake
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 10000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      i_rst_n = 1'h0;
      i_wr = 1'h0;
      i_rd = 1'h0;
      i_addr = 8'h00;
      i_wdata = 32'h0000_0000;
      i_cmp_cross = 4'h0;
      value = 10'h000;
      ovf_set = 1'h0;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'h1;
      rd(8'h00, 32'h0000_0000);
      rd(8'h04, 32'h0000_0000);
      rd(8'h0C, 32'h0000_0000);
      for (int i = 0; i < 4; i++) rd(8'h10 + 8'(i * 4), `ACLE_LIM_RESET);
      rd(8'h30, 32'h0000_0000);
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C, `ACLE_LIM_MASK);
      rd(8'h04, 32'h0000_0000);
      for (int i = 0; i < 4; i++) wr(8'h10 + 8'(i * 4), lim[i]);
      rd(8'h18, lim[2]);
      wr(8'h0C, 32'h0000_001F);
      wr(8'h00, BASE);
      rd(8'h04, 32'h0000_0004);
      chk({o_ext_divider, o_input_channel, o_input_halve, o_ref_halve, o_ref_select},
         {2'h2, 5'h05, 3'h7});
      chk({o_conv_clk_en, o_refbuf_power, o_conv_power}, 32'h0000_0007);
      repeat (45) @(posedge i_clk);
      rd(8'h04, 32'h0000_0000);
      rd(8'h0C, 32'h0042_001F);
      chk(o_converter_interrupt_line, 32'h0000_0001);
      wr(8'h0C, 32'h0002_001F);
      rd(8'h0C, 32'h0000_001F);
      conv(10'h2AB, 1'h0, BASE, 32'h0000_02AB, 32'h0045_001F);
      wr(8'h0C, 32'h001F_001F);
      conv(10'h050, 1'h1, BASE | 32'h0010_0000, 32'h0000_1400, 32'h0059_001F);
      wr(8'h0C, 32'h0000_0000);
      rd(8'h0C, 32'h0019_0000);
      chk(o_converter_interrupt_line, 32'h0000_0000);
      wr(8'h0C, 32'h001F_0000);
      rd(8'h0C, 32'h0000_0000);
      wr(8'h20, 32'h0000_01FF);
      i_cmp_cross <= 4'h4;
      repeat (5) @(posedge i_clk);
      rd(8'h24, 32'h0000_0004);
      chk(o_cmp_wake_interrupt, 32'h0000_0001);
      wr(8'h24, 32'h0000_0004);
      rd(8'h24, 32'h0000_0000);
      chk(o_cmp_wake_interrupt, 32'h0000_0000);
      wr(8'h00, BASE & 32'hFFFF_FFFD);
      wr(8'h00, BASE & 32'hFFFF_FFF5);
      wr(8'h00, 32'h0004_5310);
      @(posedge i_clk);
      #1 chk({o_conv_clk_en, o_refbuf_power, o_conv_power}, 32'h0000_0000);
      wr(8'h00, 32'h0004_5311);
      repeat (20) @(posedge i_clk);
      chk(o_conv_run, 32'h0000_0000);
      stop_test();
   end
endmodule // acle_core_tb
